// [verilog/itsc_pkg.sv]
// Purpose: Shared constants and types for integration timing and sync control
// Assumes: 40 MHz system clock; registers written over a simple byte register port
// Notes: Long integration counts are top-level parameters so simulation can shorten them
package itsc_pkg;

  // Register addresses on the byte register port
  localparam logic [4:0] ITSC_ADDR_CONTROL = 5'h00;
  localparam logic [4:0] ITSC_ADDR_TIMING = 5'h01;

  // Control register field positions
  localparam int ITSC_CTL_POWER_BIT = 0;
  localparam int ITSC_CTL_ENABLE_BIT = 1;
  localparam int ITSC_CTL_VALID_BIT = 4;
  localparam logic [7:0] ITSC_CTL_WR_MASK = 8'h03;

  // Timing register layout and reset value
  localparam logic [7:0] ITSC_TIMING_RESET = 8'h00;
  localparam logic [7:0] ITSC_TIMING_WR_MASK = 8'h7f;

  // Integration mode encodings
  localparam logic [1:0] ITSC_MODE_FREE = 2'h0;
  localparam logic [1:0] ITSC_MODE_MANUAL = 2'h1;
  localparam logic [1:0] ITSC_MODE_ONESHOT = 2'h2;
  localparam logic [1:0] ITSC_MODE_ACCUM = 2'h3;

  // Parameter encodings for nominal time and the largest pulse count power
  localparam logic [3:0] ITSC_TIMING_PARAMETER_T12 = 4'h0;
  localparam logic [3:0] ITSC_TIMING_PARAMETER_T100 = 4'h1;
  localparam logic [3:0] ITSC_TIMING_PARAMETER_T400 = 4'h2;
  localparam logic [3:0] ITSC_TIMING_PARAMETER_MAX_POW = 4'h8;

  // Timing figures in their own units and derived cycle counts
  localparam int ITSC_CLK_HZ = 40000000;
  localparam int ITSC_T12_MS = 12;
  localparam int ITSC_T100_MS = 100;
  localparam int ITSC_T400_MS = 400;
  localparam int ITSC_DELAY_NS_X10 = 24;
  localparam int ITSC_CLK_PERIOD_NS_X10 = 250;
  localparam int ITSC_T12_CYC = ITSC_CLK_HZ / 1000 * ITSC_T12_MS;
  localparam int ITSC_T100_CYC = ITSC_CLK_HZ / 1000 * ITSC_T100_MS;
  localparam int ITSC_T400_CYC = ITSC_CLK_HZ / 1000 * ITSC_T400_MS;
  localparam int ITSC_DELAY_CYC =
    (ITSC_DELAY_NS_X10 * 1000 + ITSC_CLK_PERIOD_NS_X10 - 1) / ITSC_CLK_PERIOD_NS_X10;
  localparam int ITSC_CNT_W = 24;

  // Timing register fields
  typedef struct packed {
    logic reserved;
    logic sync_edge_rising;
    logic [1:0] integration_mode_select;
    logic [3:0] timing_parameter;
  } itsc_timing_type;

  // Sequencer states, Gray coded along idle, delay, integrate
  typedef enum logic [1:0] {
    ITSC_ST_IDLE = 2'b00,
    ITSC_ST_DELAY = 2'b01,
    ITSC_ST_INTEG = 2'b11,
    ITSC_ST_DONE = 2'b10
  } itsc_state_type;

endpackage : itsc_pkg

// [verilog/itsc_top.sv]
// Purpose: Integration timing and sync control for four lockstep converter channels
// Assumes: Sync and register port inputs are synchronous to clk_sys_in
// Notes: One integrate level drives all four channels together
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - Edge select zero: falling sync edges count
// - Edge select one: rising sync edges count
// - Mode 00 free-runs back-to-back nominal conversions
// - Parameter 0,1,2 selects 12, 100, 400 ms
// - Mode 01 integrates while enable bit set
// - Mode 10 sync starts one cycle after 2.4us
// - Mode 11 integrates across programmed sync pulses
// - Accumulation count is two to power n, with n clamped at 8
// - Timing register resets to all zeros
// - All four channels integrate in lockstep
// - Integrate only with power and enable set
module itsc_top
  import itsc_pkg::*;
#(
  parameter int T12_CYC = ITSC_T12_CYC,
  parameter int T100_CYC = ITSC_T100_CYC,
  parameter int T400_CYC = ITSC_T400_CYC
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  // Byte register port
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [4:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  // Sync pin from the light source controller
  input wire logic sync_in,
  // Converter channel controls
  output logic [3:0] chan_integrate_out,
  output logic cycle_done_out
);

  logic [7:0] control_ff; // Control register: power, enable, valid
  itsc_timing_type timing_ff; // Timing register
  itsc_state_type state_ff; // Sequencer state
  itsc_state_type nxt_state;
  logic [ITSC_CNT_W-1:0] cnt_ff; // Time or pulse counter
  logic [ITSC_CNT_W-1:0] nxt_cnt;
  logic sync_prev_ff; // Last sampled sync level
  logic [7:0] rdata_ff; // Registered read data
  logic done_ff; // One-cycle completion pulse
  logic nxt_done;
  logic run; // Power and enable both set
  logic sync_start_edge; // Trigger edge for one-shot mode
  logic sync_count_edge; // Selected edge for accumulation
  logic [ITSC_CNT_W-1:0] nominal_cyc; // Selected nominal length
  logic [8:0] pulse_target; // Selected pulse count
  logic integ_level; // Common integrate level

  assign run = control_ff[ITSC_CTL_POWER_BIT] & control_ff[ITSC_CTL_ENABLE_BIT];

  // Edge detection on the sync input
  assign sync_start_edge = sync_in & ~sync_prev_ff;
  assign sync_count_edge = timing_ff.sync_edge_rising ?
                           (sync_in & ~sync_prev_ff) :
                           (~sync_in & sync_prev_ff);

  // Nominal time lookup; undefined codes fall back to the shortest
  always_comb begin
    case (timing_ff.timing_parameter)
      ITSC_TIMING_PARAMETER_T100: nominal_cyc = ITSC_CNT_W'(T100_CYC);
      ITSC_TIMING_PARAMETER_T400: nominal_cyc = ITSC_CNT_W'(T400_CYC);
      default: nominal_cyc = ITSC_CNT_W'(T12_CYC);
    endcase
  end

  // Pulse count is a power of two, clamped at the largest code
  always_comb begin
    if (timing_ff.timing_parameter > ITSC_TIMING_PARAMETER_MAX_POW) begin
      pulse_target = 9'h001 << ITSC_TIMING_PARAMETER_MAX_POW;
    end else begin
      pulse_target = 9'h001 << timing_ff.timing_parameter;
    end
  end

  // Register writes and hardware-set valid flag
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      control_ff <= 8'h00;
      timing_ff <= ITSC_TIMING_RESET;
    end else begin
      if (reg_wr_in && reg_addr_in == ITSC_ADDR_CONTROL) begin
        control_ff[ITSC_CTL_POWER_BIT] <= reg_wdata_in[ITSC_CTL_POWER_BIT];
        control_ff[ITSC_CTL_ENABLE_BIT] <= reg_wdata_in[ITSC_CTL_ENABLE_BIT];
      end
      if (done_ff) begin
        control_ff[ITSC_CTL_VALID_BIT] <= 1'b1;
      end else if (reg_wr_in && reg_addr_in == ITSC_ADDR_CONTROL &&
                   !reg_wdata_in[ITSC_CTL_ENABLE_BIT]) begin
        control_ff[ITSC_CTL_VALID_BIT] <= 1'b0;
      end
      if (reg_wr_in && reg_addr_in == ITSC_ADDR_TIMING) begin
        timing_ff <= reg_wdata_in & ITSC_TIMING_WR_MASK; // Reserved bit kept zero
      end
    end
  end

  // Read data
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rdata_ff <= 8'h00;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        ITSC_ADDR_CONTROL: rdata_ff <= control_ff;
        ITSC_ADDR_TIMING: rdata_ff <= timing_ff;
        default: rdata_ff <= 8'h00;
      endcase
    end
  end
  assign reg_rdata_out = rdata_ff;

  // Sequencer next state
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_done = 1'b0;
    if (!run) begin
      nxt_state = ITSC_ST_IDLE;
      nxt_cnt = '0;
    end else begin
      case (state_ff)
        ITSC_ST_IDLE: begin
          nxt_cnt = '0;
          case (timing_ff.integration_mode_select)
            ITSC_MODE_FREE: nxt_state = ITSC_ST_INTEG;
            ITSC_MODE_MANUAL: nxt_state = ITSC_ST_INTEG;
            ITSC_MODE_ONESHOT: begin
              if (sync_start_edge) begin
                nxt_state = ITSC_ST_DELAY;
              end
            end
            default: nxt_state = ITSC_ST_INTEG;
          endcase
        end
        ITSC_ST_DELAY: begin
          if (cnt_ff == ITSC_CNT_W'(ITSC_DELAY_CYC - 1)) begin
            nxt_state = ITSC_ST_INTEG;
            nxt_cnt = '0;
          end else begin
            nxt_cnt = cnt_ff + 1'b1;
          end
        end
        ITSC_ST_INTEG: begin
          case (timing_ff.integration_mode_select)
            ITSC_MODE_MANUAL: nxt_cnt = cnt_ff;
            ITSC_MODE_ACCUM: begin
              if (sync_count_edge) begin
                if (cnt_ff[8:0] == pulse_target - 9'h001) begin
                  nxt_state = ITSC_ST_DONE;
                  nxt_done = 1'b1;
                  nxt_cnt = '0;
                end else begin
                  nxt_cnt = cnt_ff + 1'b1;
                end
              end
            end
            default: begin
              if (cnt_ff == nominal_cyc - 1'b1) begin
                nxt_done = 1'b1;
                nxt_cnt = '0;
                nxt_state = (timing_ff.integration_mode_select == ITSC_MODE_FREE) ?
                            ITSC_ST_INTEG : ITSC_ST_DONE;
              end else begin
                nxt_cnt = cnt_ff + 1'b1;
              end
            end
          endcase
        end
        ITSC_ST_DONE: begin
          // One-shot waits for the next trigger; accumulation restarts
          if (timing_ff.integration_mode_select == ITSC_MODE_ONESHOT) begin
            nxt_state = ITSC_ST_IDLE;
          end else if (timing_ff.integration_mode_select == ITSC_MODE_ACCUM) begin
            nxt_state = ITSC_ST_INTEG;
          end else begin
            nxt_state = ITSC_ST_IDLE;
          end
        end
        default: nxt_state = ITSC_ST_IDLE;
      endcase
    end
  end

  // Sequencer registers
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_ff <= ITSC_ST_IDLE;
      cnt_ff <= '0;
      done_ff <= 1'b0;
      sync_prev_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      done_ff <= nxt_done;
      sync_prev_ff <= sync_in;
    end
  end

  // One integrate level, gated by power and enable, drives every channel
  assign integ_level = (state_ff == ITSC_ST_INTEG) && run;
  assign chan_integrate_out = {4{integ_level}};
  assign cycle_done_out = done_ff;

endmodule : itsc_top

`default_nettype wire

// [tb/itsc_properties.sv]
// Purpose: Port checker for itsc_top
// Assumes: Registers change only through observed port writes
// Notes: Shadows timing and control fields from the write strobe
`timescale 1ns/100ps
`default_nettype none
module itsc_chk
  import itsc_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  // Register port
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [4:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic [7:0] reg_rdata_out,
  // Sync and channels
  input wire logic sync_in,
  input wire logic [3:0] chan_integrate_out,
  input wire logic cycle_done_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);
  logic [6:0] tim_ff; // Shadow timing fields
  logic [1:0] ctl_ff; // Shadow power and enable
  wire logic [1:0] md = tim_ff[5:4]; // Current mode
  wire logic run = &ctl_ff; // Power and enable both set
  // Track register writes
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tim_ff <= '0;
      ctl_ff <= '0;
    end else if (reg_wr_in && reg_addr_in == ITSC_ADDR_TIMING) begin
      tim_ff <= reg_wdata_in[6:0];
    end else if (reg_wr_in && reg_addr_in == ITSC_ADDR_CONTROL) begin
      ctl_ff <= reg_wdata_in[1:0];
    end
  end
  a_chan_lockstep: assert property (
    chan_integrate_out inside {4'h0, 4'hf}) else $error("Channels differ");
  a_timing_readback: assert property (
    reg_rd_in && !reg_wr_in && reg_addr_in == ITSC_ADDR_TIMING
    |=> reg_rdata_out == {1'h0, tim_ff}) else $error("Timing readback wrong");
  a_gate_off: assert property (
    chan_integrate_out != 4'h0 |-> run) else $error("Integrating while off");
  a_manual_on: assert property (
    (run && md == ITSC_MODE_MANUAL)[*2] |-> chan_integrate_out == 4'hf)
    else $error("Manual mode not integrating");
  a_free_cont: assert property (
    run && md == ITSC_MODE_FREE && cycle_done_out |-> chan_integrate_out == 4'hf)
    else $error("Free run paused");
  a_done_single: assert property (
    cycle_done_out |=> !cycle_done_out) else $error("Done pulse too long");
  a_sync_delay: assert property (
    run && md == ITSC_MODE_ONESHOT && chan_integrate_out == 4'h0 && $rose(sync_in)
    |=> (chan_integrate_out == 4'h0)[*8]) else $error("Start delay missing");
  a_oneshot_end: assert property (
    md == ITSC_MODE_ONESHOT && cycle_done_out |=> (chan_integrate_out == 4'h0)[*4])
    else $error("One shot repeated");
endmodule : itsc_chk
bind itsc_top itsc_chk u_chk (.clk_sys_in, .rst_b_in, .reg_wr_in, .reg_rd_in, .reg_addr_in,
  .reg_wdata_in, .reg_rdata_out, .sync_in, .chan_integrate_out, .cycle_done_out);
`default_nettype wire

// [tb/itsc_sync_src.sv]
// Purpose: Pulsed light source driving the sync pin
// Assumes: Sync idles low between bursts
// Notes: High 50us and low 3.6us at the 40 MHz clock
`timescale 1ns/100ps
`default_nettype none
module itsc_sync_src (
  // Clock
  input wire logic clk_sys_in,
  // Sync pin
  output logic sync_out
);
  initial sync_out = 1'h0;
  // Toggle the pin k times, holding each level its minimum time
  task automatic toggle(input int k);
    repeat (k) begin
      sync_out = ~sync_out;
      repeat (sync_out ? 2000 : 144) @(negedge clk_sys_in);
    end
  endtask : toggle
endmodule : itsc_sync_src
`default_nettype wire

// [tb/testbench.sv]
// Purpose: Directed test of integration timing and sync control
// Assumes: Short nominal times 20, 40 and 80 cycles
// Notes: Inputs change on the falling clock edge
`timescale 1ns/100ps
`default_nettype none
module testbench
  import itsc_pkg::*;
;
  logic clk_sys_in, rst_b_in, reg_wr_in, reg_rd_in, sync_in, cycle_done_out;
  logic [4:0] reg_addr_in;
  logic [7:0] reg_wdata_in, reg_rdata_out;
  logic [3:0] chan_integrate_out;
  int mismatches = 0;
  int checks_done = 0;
  int dones = 0; // Done pulses seen
  int dones_base = 0; // Done count at scenario start
  int cnt;
  localparam int TCYC [3] = '{20, 40, 80};
  itsc_top #(.T12_CYC(20), .T100_CYC(40), .T400_CYC(80)) uut (.clk_sys_in, .rst_b_in,
    .reg_wr_in, .reg_rd_in, .reg_addr_in, .reg_wdata_in, .reg_rdata_out, .sync_in,
    .chan_integrate_out, .cycle_done_out);
  itsc_sync_src src (.clk_sys_in, .sync_out(sync_in));
  // Clock at 40 MHz
  initial begin
    clk_sys_in = 1'h0;
    forever #12.5 clk_sys_in = ~clk_sys_in;
  end
  // Count completed cycles
  always @(negedge clk_sys_in) if (cycle_done_out === 1'h1) dones++;
  task automatic complete_run();
    $display("TB: checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    reg_addr_in = a;
    reg_wdata_in = d;
    reg_wr_in = 1'h1;
    @(negedge clk_sys_in);
    reg_wr_in = 1'h0;
    // Let one edge pass so the next write never re-raises the strobe at once
    @(negedge clk_sys_in);
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [7:0] exp);
    reg_addr_in = a;
    reg_rd_in = 1'h1;
    @(negedge clk_sys_in);
    reg_rd_in = 1'h0;
    @(negedge clk_sys_in);
    chk(reg_rdata_out, exp);
  endtask : rd
  // Cycles until the next done pulse, bounded
  task automatic wait_done(output int n);
    n = 0;
    do begin
      @(negedge clk_sys_in);
      n++;
      if (n > 5000) begin
        mismatches++;
        complete_run();
      end
    end while (cycle_done_out !== 1'h1);
  endtask : wait_done
  initial begin
    {rst_b_in, reg_wr_in, reg_rd_in} = 3'h0;
    reg_addr_in = 5'h00;
    reg_wdata_in = 8'h00;
    repeat (6) @(negedge clk_sys_in);
    rst_b_in = 1'h1;
    rd(ITSC_ADDR_TIMING, 8'h00);
    rd(ITSC_ADDR_CONTROL, 8'h00);
    wr(ITSC_ADDR_TIMING, 8'h7f);
    rd(ITSC_ADDR_TIMING, 8'h7f);
    rd(5'h05, 8'h00);
    // Free run with each nominal time
    for (int p = 0; p < 3; p++) begin
      wr(ITSC_ADDR_TIMING, 8'(p));
      wr(ITSC_ADDR_CONTROL, 8'h03);
      wait_done(cnt);
      wait_done(cnt);
      chk(8'(cnt), 8'(TCYC[p]));
      chk({4'h0, chan_integrate_out}, 8'h0f);
      wr(ITSC_ADDR_CONTROL, 8'h00);
    end
    // Manual start, then drop power or enable
    wr(ITSC_ADDR_TIMING, 8'h10);
    wr(ITSC_ADDR_CONTROL, 8'h03);
    chk({4'h0, chan_integrate_out}, 8'h0f);
    for (int c = 1; c < 3; c++) begin
      wr(ITSC_ADDR_CONTROL, 8'(c));
      @(negedge clk_sys_in);
      chk({4'h0, chan_integrate_out}, 8'h00);
    end
    // One sync triggered cycle after the start delay
    wr(ITSC_ADDR_TIMING, 8'h20);
    wr(ITSC_ADDR_CONTROL, 8'h03);
    dones_base = dones;
    fork
      src.toggle(2);
      begin
        cnt = 0;
        while (chan_integrate_out !== 4'hf && cnt < 300) begin
          @(negedge clk_sys_in);
          cnt++;
        end
      end
    join
    chk({7'h0, cnt >= ITSC_DELAY_CYC && cnt <= ITSC_DELAY_CYC + 5}, 8'h01);
    chk(8'(dones - dones_base), 8'h01);
    // Accumulate on each edge kind, counts 1 and 8
    for (int e = 0; e < 2; e++) begin
      for (int n = 0; n < 4; n += 3) begin
        wr(ITSC_ADDR_CONTROL, 8'h00);
        wr(ITSC_ADDR_TIMING, {2'(e), 2'h3, 4'(n)});
        wr(ITSC_ADDR_CONTROL, 8'h03);
        dones_base = dones;
        src.toggle(2 * (1 << n) - 1);
        chk(8'(dones - dones_base), 8'(e));
        src.toggle(1);
        chk(8'(dones - dones_base), 8'h01);
      end
    end
    complete_run();
  end
endmodule : testbench
`default_nettype wire
